// file: logic/tirl_consts.svh
`ifndef TIRL_CONSTS_SVH
`define TIRL_CONSTS_SVH

// Register offsets
`define TIRL_OFS_MAIN_EN    6'h02
`define TIRL_OFS_AUX_EN     6'h03
`define TIRL_OFS_MAIN_REQ   6'h04
`define TIRL_OFS_AUX_REQ    6'h05

// Reset values
`define TIRL_RST_MAIN_EN    8'h80
`define TIRL_RST_AUX_EN     8'h00
`define TIRL_RST_MAIN_REQ   8'h14
`define TIRL_RST_AUX_REQ    8'h00

// Shared bit positions
`define TIRL_BIT_SET_SEL    7
`define TIRL_BIT_PUSH_PULL  7
`define TIRL_BIT_INVERT     7

// Primary request bits
`define TIRL_BIT_TX         6
`define TIRL_BIT_RX         5
`define TIRL_BIT_IDLE       4
`define TIRL_BIT_HIGH       3
`define TIRL_BIT_LOW        2
`define TIRL_BIT_ERR        1
`define TIRL_BIT_TIMER      0

// Auxiliary request bits
`define TIRL_BIT_SIG        4
`define TIRL_BIT_MODE       3
`define TIRL_BIT_CRC        2
`define TIRL_BIT_FON        1
`define TIRL_BIT_FOFF       0

// Timer value just before its last decrement
`define TIRL_TIMER_LAST     16'h0001

`endif

// file: logic/tirl_pkg.sv
package tirl_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } tirl_reg_req_t;

  typedef struct packed {
    logic       start;
    logic [3:0] code;
  } tirl_cmd_t;

  typedef enum logic {
    TIRL_MD_IDLE,
    TIRL_MD_RUN
  } tirl_md_state_t;

endpackage

// file: logic/tirl_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "tirl_consts.svh"

//Contract
// - Auxiliary enable bit 7 set: pin push-pull; clear: pin open-drain.
// - Auxiliary enable bits 4..0 gate sig-in, mode, CRC, field on/off.
// - Primary request write: bit 7 one sets marked bits, zero clears.
// - Transmit-done flag bit 6 sets after the last outgoing bit.
// - Receive flag bit 5 sets at end of valid incoming stream.
// - With receive-only-valid option, receive flag needs FIFO data present.
// - Idle flag bit 4 sets when a command finishes by itself.
// - Unknown command start returns command to idle and sets idle flag.
// - Host writing the idle command never sets the idle flag.
// - FIFO high flag bit 3 latches rising high status until cleared.
// - FIFO low flag bit 2 latches rising low status until cleared.
// - Error flag bit 1 sets while any error status bit is set.
// - Timer flag bit 0 sets when timer count decrements to zero.
// - Auxiliary request write: bit 7 one sets marked bits, zero clears.
// - Sig-in flag bit 4 sets on every edge of the sig-in pin.
// - Mode flag bit 3 sets when the mode detector finds the mode.
// - Mode detector starts on auto anticollision or RF reset; stops after detection.
// - Mode detector restarts automatically after every RF reset.
// - Checksum flag bit 2 sets when CRC command ends processing.
// - Field-on flag bit 1 sets when an external field appears.
// - Field-off flag bit 0 sets when the external field disappears.
// - Primary enable bit 7 inverts the pin against combined status.
// - Primary enable bits 6..0 gate the matching primary requests.
module tirl_irq #(
  parameter logic [3:0]  CMD_IDLE     = 4'h0,
  parameter logic [3:0]  CMD_CRC      = 4'h3,
  parameter logic [3:0]  CMD_AUTO_ANTICOLLISION_COMMAND = 4'hd,
  parameter logic [15:0] KNOWN_CMDS   = 16'hffff
) (
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire tirl_pkg::tirl_reg_req_t reg_req_in,
  output var  logic [7:0]             reg_rdata_out,
  output var  logic                   reg_rvalid_out,
  input  wire tirl_pkg::tirl_cmd_t    cmd_in,
  input  wire logic                   cmd_finish_in,
  output var  logic [3:0]             command_out,
  input  wire logic                   tx_last_bit_in,
  input  wire logic                   rx_valid_end_in,
  input  wire logic                   receive_only_valid_option_in,
  input  wire logic                   fifo_has_data_in,
  input  wire logic                   fifo_high_status_in,
  input  wire logic                   fifo_low_status_in,
  input  wire logic [7:0]             error_status_in,
  input  wire logic                   timer_decrement_in,
  input  wire logic [15:0]            timer_count_in,
  input  wire logic                   secure_sig_in_pin_in,
  input  wire logic                   mode_found_in,
  input  wire logic                   rf_reset_in,
  output var  logic                   mode_detector_run_out,
  input  wire logic                   crc_all_done_in,
  input  wire logic                   rf_field_in,
  output var  logic                   irq_status_out,
  output var  logic                   irq_pin_out,
  output var  logic                   irq_pin_oe_out
);
  import tirl_pkg::*;

  logic [7:0]     main_en_q;
  logic [7:0]     aux_en_q;
  logic [6:0]     main_q;
  logic [6:0]     main_d;
  logic [4:0]     aux_q;
  logic [4:0]     aux_d;
  logic [6:0]     main_evt;
  logic [4:0]     aux_evt;
  logic [3:0]     command_q;
  tirl_md_state_t md_state_q;
  logic           high_prev_q;
  logic           low_prev_q;
  logic           sig_s1_q;
  logic           sig_s2_q;
  logic           sig_s3_q;
  logic           rf_s1_q;
  logic           rf_s2_q;
  logic           rf_s3_q;
  logic           wr_main_en;
  logic           wr_aux_en;
  logic           wr_main_req;
  logic           wr_aux_req;
  logic           cmd_known;
  logic           idle_evt;
  logic           irq_status_d;
  logic           irq_level_d;

  function automatic logic is_known(input logic [3:0] code);
    return KNOWN_CMDS[code];
  endfunction

  // Write-one-to-mark update; hardware events win over a same-cycle clear
  function automatic logic [6:0] mark_update(input logic [6:0] cur,
                                             input logic       wr,
                                             input logic [7:0] wdata,
                                             input logic [6:0] evt);
    logic [6:0] nxt;
    nxt = cur;
    if (wr) begin
      if (wdata[`TIRL_BIT_SET_SEL]) begin
        nxt = cur | wdata[6:0];
      end else begin
        nxt = cur & ~wdata[6:0];
      end
    end
    return nxt | evt;
  endfunction

  assign wr_main_en  = reg_req_in.wr && reg_req_in.addr == `TIRL_OFS_MAIN_EN;
  assign wr_aux_en   = reg_req_in.wr && reg_req_in.addr == `TIRL_OFS_AUX_EN;
  assign wr_main_req = reg_req_in.wr && reg_req_in.addr == `TIRL_OFS_MAIN_REQ;
  assign wr_aux_req  = reg_req_in.wr && reg_req_in.addr == `TIRL_OFS_AUX_REQ;

  // Enable registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      main_en_q <= `TIRL_RST_MAIN_EN;
      aux_en_q  <= `TIRL_RST_AUX_EN;
    end else begin
      if (wr_main_en) begin
        main_en_q <= reg_req_in.wdata;
      end
      if (wr_aux_en) begin
        // Bits 6..5 reserved: held at zero
        aux_en_q <= reg_req_in.wdata & 8'h9f;
      end
    end
  end

  // Command field tracking
  assign cmd_known = is_known(cmd_in.code);
  // Host start of the idle code is a known command and raises nothing
  assign idle_evt = (cmd_in.start && !cmd_known) ||
                    (!cmd_in.start && cmd_finish_in &&
                     command_q != CMD_IDLE);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      command_q <= CMD_IDLE;
    end else if (cmd_in.start) begin
      command_q <= cmd_known ? cmd_in.code : CMD_IDLE;
    end else if (cmd_finish_in) begin
      command_q <= CMD_IDLE;
    end
  end

  // Pin synchronisers plus one stage for edge detection
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sig_s1_q <= 1'b0;
      sig_s2_q <= 1'b0;
      sig_s3_q <= 1'b0;
      rf_s1_q  <= 1'b0;
      rf_s2_q  <= 1'b0;
      rf_s3_q  <= 1'b0;
    end else begin
      sig_s1_q <= secure_sig_in_pin_in;
      sig_s2_q <= sig_s1_q;
      sig_s3_q <= sig_s2_q;
      rf_s1_q  <= rf_field_in;
      rf_s2_q  <= rf_s1_q;
      rf_s3_q  <= rf_s2_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      high_prev_q <= 1'b0;
      low_prev_q  <= 1'b0;
    end else begin
      high_prev_q <= fifo_high_status_in;
      low_prev_q  <= fifo_low_status_in;
    end
  end

  // Mode detector run state
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      md_state_q <= TIRL_MD_IDLE;
    end else begin
      case (md_state_q)
        TIRL_MD_IDLE: begin
          if (rf_reset_in ||
              (cmd_in.start && cmd_in.code == CMD_AUTO_ANTICOLLISION_COMMAND)) begin
            md_state_q <= TIRL_MD_RUN;
          end
        end
        TIRL_MD_RUN: begin
          if (mode_found_in && !rf_reset_in) begin
            md_state_q <= TIRL_MD_IDLE;
          end
        end
        default: md_state_q <= TIRL_MD_IDLE;
      endcase
    end
  end

  // Hardware request events
  always_comb begin
    main_evt = 7'h00;
    main_evt[`TIRL_BIT_TX]    = tx_last_bit_in;
    main_evt[`TIRL_BIT_RX]    = rx_valid_end_in &&
                                (!receive_only_valid_option_in ||
                                 fifo_has_data_in);
    main_evt[`TIRL_BIT_IDLE]  = idle_evt;
    main_evt[`TIRL_BIT_HIGH]  = fifo_high_status_in && !high_prev_q;
    main_evt[`TIRL_BIT_LOW]   = fifo_low_status_in && !low_prev_q;
    main_evt[`TIRL_BIT_ERR]   = |error_status_in;
    main_evt[`TIRL_BIT_TIMER] = timer_decrement_in &&
                                timer_count_in == `TIRL_TIMER_LAST;
  end

  always_comb begin
    aux_evt = 5'h00;
    aux_evt[`TIRL_BIT_SIG]  = sig_s2_q ^ sig_s3_q;
    aux_evt[`TIRL_BIT_MODE] = mode_found_in &&
                              md_state_q == TIRL_MD_RUN;
    aux_evt[`TIRL_BIT_CRC]  = crc_all_done_in && command_q == CMD_CRC;
    aux_evt[`TIRL_BIT_FON]  = rf_s2_q && !rf_s3_q;
    aux_evt[`TIRL_BIT_FOFF] = !rf_s2_q && rf_s3_q;
  end

  // Flags only fall through host writes
  assign main_d = mark_update(main_q, wr_main_req, reg_req_in.wdata,
                              main_evt);
  assign aux_d  = 5'(mark_update({2'b00, aux_q}, wr_aux_req,
                                 reg_req_in.wdata,
                                 {2'b00, aux_evt}));

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      main_q <= 7'(`TIRL_RST_MAIN_REQ);
    end else begin
      main_q <= main_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      aux_q <= 5'(`TIRL_RST_AUX_REQ);
    end else begin
      aux_q <= aux_d;
    end
  end

  // Combined status and pin drive
  assign irq_status_d = |(main_q & main_en_q[6:0]) |
                        |(aux_q & aux_en_q[4:0]);
  assign irq_level_d  = irq_status_d ^ main_en_q[`TIRL_BIT_INVERT];

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_status_out <= 1'b0;
      irq_pin_out    <= 1'b0;
      irq_pin_oe_out <= 1'b0;
    end else begin
      irq_status_out <= irq_status_d;
      if (aux_en_q[`TIRL_BIT_PUSH_PULL]) begin
        irq_pin_out    <= irq_level_d;
        irq_pin_oe_out <= 1'b1;
      end else begin
        // Open drain: only a low level is driven
        irq_pin_out    <= 1'b0;
        irq_pin_oe_out <= !irq_level_d;
      end
    end
  end

  // Register readback, one cycle after the read strobe
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_req_in.rd;
      if (reg_req_in.rd) begin
        case (reg_req_in.addr)
          `TIRL_OFS_MAIN_EN:  reg_rdata_out <= main_en_q;
          `TIRL_OFS_AUX_EN:   reg_rdata_out <= aux_en_q;
          `TIRL_OFS_MAIN_REQ: reg_rdata_out <= {1'b0, main_q};
          `TIRL_OFS_AUX_REQ:  reg_rdata_out <= {3'b000, aux_q};
          default:            reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      command_out           <= CMD_IDLE;
      mode_detector_run_out <= 1'b0;
    end else begin
      command_out           <= command_q;
      mode_detector_run_out <= md_state_q == TIRL_MD_RUN;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence s_unknown_start;
    cmd_in.start && !cmd_known;
  endsequence

  sequence s_back_to_idle;
    command_q == CMD_IDLE && main_q[`TIRL_BIT_IDLE];
  endsequence

  a_pin_push_pull: assert property (
    aux_en_q[`TIRL_BIT_PUSH_PULL] |=> irq_pin_oe_out)
    else $error("push-pull pin not driven");

  a_pin_open_drain: assert property (
    !aux_en_q[`TIRL_BIT_PUSH_PULL] |=> !irq_pin_out)
    else $error("open-drain pin drove high");

  a_aux_gate: assert property (
    (aux_q & aux_en_q[4:0]) != 5'h00 |=> irq_status_out)
    else $error("enabled auxiliary flag missed status");

  a_main_clear: assert property (
    wr_main_req && !reg_req_in.wdata[`TIRL_BIT_SET_SEL] |=>
      (main_q & $past(reg_req_in.wdata[6:0]) & ~$past(main_evt)) == 7'h00)
    else $error("primary clear write ignored");

  a_tx_flag: assert property (
    tx_last_bit_in |=> main_q[`TIRL_BIT_TX])
    else $error("transmit-done flag not set");

  a_rx_gated: assert property (
    rx_valid_end_in && receive_only_valid_option_in && !fifo_has_data_in &&
    !wr_main_req && !main_q[`TIRL_BIT_RX] |=> !main_q[`TIRL_BIT_RX])
    else $error("receive flag set with empty fifo");

  a_unknown_cmd: assert property (
    s_unknown_start |=> s_back_to_idle)
    else $error("unknown command not returned to idle");

  a_host_idle: assert property (
    cmd_in.start && cmd_in.code == CMD_IDLE && cmd_known &&
    !wr_main_req && !main_q[`TIRL_BIT_IDLE] |=> !main_q[`TIRL_BIT_IDLE])
    else $error("host idle write raised idle flag");

  a_sig_edge: assert property (
    $changed(secure_sig_in_pin_in) && !wr_aux_req ##1 !wr_aux_req[*2]
      |=> aux_q[`TIRL_BIT_SIG])
    else $error("sig-in edge not flagged");

  a_mode_stop: assert property (
    md_state_q == TIRL_MD_RUN && mode_found_in && !rf_reset_in |=>
      md_state_q == TIRL_MD_IDLE && aux_q[`TIRL_BIT_MODE])
    else $error("mode detector did not stop and flag");

  a_field_off: assert property (
    $fell(rf_s2_q) |=> aux_q[`TIRL_BIT_FOFF])
    else $error("field-off not flagged");

  a_pin_level: assert property (
    aux_en_q[`TIRL_BIT_PUSH_PULL] && $stable(aux_en_q) |=>
      irq_pin_out == (irq_status_out ^ $past(main_en_q[`TIRL_BIT_INVERT])))
    else $error("pin level disagrees with status and polarity");

endmodule

`default_nettype wire

// file: verif/tirl_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module tirl_host_model (
  input  wire logic irq_pin_in,
  input  wire logic irq_oe_in,
  output var  logic irq_wire_out
);
  // Board pull-up holds the line high whenever the device lets go
  always_comb begin
    irq_wire_out = irq_oe_in ? irq_pin_in : 1'b1;
  end
endmodule

`default_nettype wire

// file: verif/transceiver_interrupt_request_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tirl_consts.svh"

module transceiver_interrupt_request_logic_tb;
  import tirl_pkg::*;
  logic          clk;
  logic          rst;
  tirl_reg_req_t req;
  tirl_cmd_t     cmd;
  logic [7:0]    ev;
  logic [7:0]    rdata;
  logic          rvalid;
  logic [3:0]    command;
  logic          opt;
  logic          fdata;
  logic          fhi;
  logic          flo;
  logic [7:0]    errs;
  logic [15:0]   tcount;
  logic          sig;
  logic          field;
  logic          md_run;
  logic          status;
  logic          pin;
  logic          pin_oe;
  logic          wire_lvl;
  logic [7:0]    v;
  logic [7:0]    w;
  logic [7:0]    m;
  logic [7:0]    c;
  logic [7:0]    em;
  logic [7:0]    ea;
  logic          st;
  int            err_count;
  int            num_checks;

  tirl_irq #(.KNOWN_CMDS(16'h7fff)) i_dut (
    .clk_in                       (clk),
    .reset_in                     (rst),
    .reg_req_in                   (req),
    .reg_rdata_out                (rdata),
    .reg_rvalid_out               (rvalid),
    .cmd_in                       (cmd),
    .cmd_finish_in                (ev[0]),
    .command_out                  (command),
    .tx_last_bit_in               (ev[1]),
    .rx_valid_end_in              (ev[2]),
    .receive_only_valid_option_in (opt),
    .fifo_has_data_in             (fdata),
    .fifo_high_status_in          (fhi),
    .fifo_low_status_in           (flo),
    .error_status_in              (errs),
    .timer_decrement_in           (ev[3]),
    .timer_count_in               (tcount),
    .secure_sig_in_pin_in         (sig),
    .mode_found_in                (ev[4]),
    .rf_reset_in                  (ev[5]),
    .mode_detector_run_out        (md_run),
    .crc_all_done_in              (ev[6]),
    .rf_field_in                  (field),
    .irq_status_out               (status),
    .irq_pin_out                  (pin),
    .irq_pin_oe_out               (pin_oe)
  );

  tirl_host_model i_host (
    .irq_pin_in   (pin),
    .irq_oe_in    (pin_oe),
    .irq_wire_out (wire_lvl)
  );

  task automatic chk_byte(input string n, input logic [7:0] e,
                          input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_byte(n, {7'h00, e}, {7'h00, g});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e,
                    input string n);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    chk_byte(n, e, rdata);
    chk_bit("rvalid", 1'b1, rvalid);
  endtask

  // Host duty: flags are only ever cleared from this side
  task automatic clr();
    wr(`TIRL_OFS_MAIN_REQ, 8'h7f);
    wr(`TIRL_OFS_AUX_REQ, 8'h7f);
  endtask

  task automatic evt(input logic [7:0] mk, input logic [5:0] a,
                     input logic [7:0] e, input string n);
    @(negedge clk);
    ev = mk;
    @(negedge clk);
    ev = 8'h00;
    rd(a, e, n);
    clr();
  endtask

  task automatic start(input logic [3:0] code);
    @(negedge clk);
    cmd = '{start: 1'b1, code: code};
    @(negedge clk);
    cmd = '0;
  endtask

  function automatic logic exp_st(logic [7:0] me, logic [7:0] ae,
                                  logic [7:0] mr, logic [7:0] ar);
    return (|(me[6:0] & mr[6:0])) | (|(ae[4:0] & ar[4:0]));
  endfunction

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #100000;
    err_count++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    req = '0;
    cmd = '0;
    ev = 8'h00;
    opt = 1'b0;
    fdata = 1'b0;
    fhi = 1'b0;
    flo = 1'b0;
    errs = 8'h00;
    tcount = 16'h0001;
    sig = 1'b0;
    field = 1'b0;
    void'($urandom(32'hdb10_c554));
    cyc(8);
    rst = 1'b0;
    rd(`TIRL_OFS_MAIN_EN, 8'h80, "main_en");
    rd(`TIRL_OFS_AUX_EN, 8'h00, "aux_en");
    rd(`TIRL_OFS_MAIN_REQ, 8'h14, "main_req");
    rd(`TIRL_OFS_AUX_REQ, 8'h00, "aux_req");
    rd(6'h3f, 8'h00, "unmapped");
    chk_bit("pin_wire", 1'b1, wire_lvl);
    clr();
    rd(`TIRL_OFS_MAIN_REQ, 8'h00, "main_cleared");
    evt(8'h02, `TIRL_OFS_MAIN_REQ, 8'h40, "tx");
    evt(8'h04, `TIRL_OFS_MAIN_REQ, 8'h20, "rx");
    evt(8'h08, `TIRL_OFS_MAIN_REQ, 8'h01, "timer");
    tcount = 16'h0002;
    evt(8'h08, `TIRL_OFS_MAIN_REQ, 8'h00, "timer_early");
    opt = 1'b1;
    evt(8'h04, `TIRL_OFS_MAIN_REQ, 8'h00, "rx_empty");
    fdata = 1'b1;
    evt(8'h04, `TIRL_OFS_MAIN_REQ, 8'h20, "rx_data");
    evt(8'h10, `TIRL_OFS_AUX_REQ, 8'h00, "mode_idle");
    start(4'h5);
    evt(8'h01, `TIRL_OFS_MAIN_REQ, 8'h10, "finish");
    start(4'h5);
    start(4'h0);
    evt(8'h00, `TIRL_OFS_MAIN_REQ, 8'h00, "host_idle");
    start(4'hf);
    cyc(3);
    chk_byte("unknown_cmd", 8'h00, {4'h0, command});
    evt(8'h00, `TIRL_OFS_MAIN_REQ, 8'h10, "unknown_flag");
    evt(8'h40, `TIRL_OFS_AUX_REQ, 8'h00, "crc_off");
    start(4'h3);
    evt(8'h40, `TIRL_OFS_AUX_REQ, 8'h04, "crc");
    start(4'hd);
    cyc(1);
    chk_bit("md_started", 1'b1, md_run);
    evt(8'h10, `TIRL_OFS_AUX_REQ, 8'h08, "mode");
    chk_bit("md_stopped", 1'b0, md_run);
    evt(8'h20, `TIRL_OFS_AUX_REQ, 8'h00, "rf_reset");
    chk_bit("md_restart", 1'b1, md_run);
    fhi = 1'b1;
    flo = 1'b1;
    cyc(2);
    fhi = 1'b0;
    flo = 1'b0;
    cyc(2);
    evt(8'h00, `TIRL_OFS_MAIN_REQ, 8'h0c, "fifo_alerts");
    errs = 8'($urandom) | 8'h01;
    cyc(2);
    errs = 8'h00;
    evt(8'h00, `TIRL_OFS_MAIN_REQ, 8'h02, "error");
    sig = 1'b1;
    cyc(5);
    evt(8'h00, `TIRL_OFS_AUX_REQ, 8'h10, "sig_rise");
    sig = 1'b0;
    cyc(5);
    evt(8'h00, `TIRL_OFS_AUX_REQ, 8'h10, "sig_fall");
    field = 1'b1;
    cyc(5);
    evt(8'h00, `TIRL_OFS_AUX_REQ, 8'h02, "field_on");
    field = 1'b0;
    cyc(5);
    evt(8'h00, `TIRL_OFS_AUX_REQ, 8'h01, "field_off");
    em = 8'h00;
    ea = 8'h00;
    for (int i = 0; i < 16; i++) begin
      v = 8'($urandom);
      w = 8'($urandom);
      m = 8'($urandom);
      c = 8'($urandom);
      wr(`TIRL_OFS_MAIN_EN, v);
      wr(`TIRL_OFS_AUX_EN, w);
      rd(`TIRL_OFS_AUX_EN, w & 8'h9f, "aux_en_rw");
      wr(`TIRL_OFS_MAIN_REQ, {1'b1, m[6:0]});
      wr(`TIRL_OFS_MAIN_REQ, {1'b0, c[6:0]});
      wr(`TIRL_OFS_AUX_REQ, {1'b1, c[6:0]});
      wr(`TIRL_OFS_AUX_REQ, {1'b0, m[6:0]});
      em = (em | m) & ~c & 8'h7f;
      ea = (ea | c) & ~m & 8'h1f;
      rd(`TIRL_OFS_MAIN_REQ, em, "main_setclr");
      rd(`TIRL_OFS_AUX_REQ, ea, "aux_setclr");
      cyc(2);
      st = exp_st(v, w, em, ea);
      chk_bit("status", st, status);
      chk_bit("pin_wire", st ^ v[7], wire_lvl);
      chk_bit("pin_oe", w[7] | ~(st ^ v[7]), pin_oe);
    end
    final_report();
  end
endmodule

`default_nettype wire
